// file: core/ccr_config_reg.sv
// Card configuration register bank with APB access
// Summary of operation
// - Top two bits hold layout version, coded zero.
// - Fields are read-only, one-time programmable or rewritable; read-only ignore writes.
// - Multi-bit fields are unsigned binary, most significant bit first.
// - Async access time 0x26 on binary cells, 0x0f on multi-level cells.
// - Clocked access time at bits 111:104 is zero.
// - Transfer rate code 0x32 at bits 103:96.
// - Command class mask 0x1f5 at bits 95:84.
// - Read and write block length both code 9, 512 bytes.
// - Partial read allowed bit set, partial write bit clear.
// - Capacity size and multiplier are model parameters.
// - Four current codes 4, 3, 4, 4 at bits 61:50.
// - Single block erase set; sector size code 0x1f.
// - Protect group size 0x7f; protect group enable set.
// - Bits 30:29 read as zero.
// - Write speed ratio 4 on binary cells, 2 on multi-level.
// - Checksum in bits 7:1; bit 0 always one.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module ccr_config_reg
#(
  parameter bit          MULTI_LEVEL_CELL = 1'b0,
  parameter logic [11:0] CAPACITY_SIZE    = 12'h000,
  parameter logic [2:0]  CAPACITY_MULT    = 3'h0
)
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ccr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ccr_pkg::DATA_W-1:0]  pwdata,
  output logic      [ccr_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [ccr_pkg::CFG_W-1:0]   card_specific_config,
  output logic                             config_valid
);
  import ccr_pkg::*;

  if (CAPACITY_SIZE == 12'h000)
  begin : g_check
    $error("ccr_config_reg: capacity size of zero is not a card");
  end

  // Whole register from the programmable bits and a checksum
  function automatic logic [CFG_W-1:0] build_cfg
  (
    input logic [5:0] wr_bits,
    input logic [6:0] crc
  );
    logic [CFG_W-1:0] v;
    v = '0;
    v[127:126] = LAYOUT_VERSION;
    v[119:112] = MULTI_LEVEL_CELL ? ASYNC_TIME_MLC : ASYNC_TIME_BINARY;
    v[111:104] = CLOCKED_TIME;
    v[103:96]  = TRANSFER_RATE;
    v[95:84]   = COMMAND_CLASS_MASK;
    v[83:80]   = BLOCK_LENGTH;
    v[79]      = 1'b1;
    v[73:62]   = CAPACITY_SIZE;
    v[61:59]   = READ_CUR_LOW;
    v[58:56]   = READ_CUR_HIGH;
    v[55:53]   = WRITE_CUR_LOW;
    v[52:50]   = WRITE_CUR_HIGH;
    v[49:47]   = CAPACITY_MULT;
    v[46]      = 1'b1;
    v[45:39]   = ERASE_SECTOR_SIZE;
    v[38:32]   = PROTECT_GROUP_SIZE;
    v[31]      = 1'b1;
    v[30:29]   = 2'h0;
    v[28:26]   = MULTI_LEVEL_CELL ? WRITE_RATIO_MLC : WRITE_RATIO_BINARY;
    v[25:22]   = BLOCK_LENGTH;
    v[21]      = 1'b0;
    v[WR_HI:WR_LO] = wr_bits;
    v[7:1]     = crc;
    v[0]       = 1'b1;
    return v;
  endfunction

  function automatic logic [2:0] word_sel(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_WORD0:  return 3'h0;
      OFF_WORD1:  return 3'h1;
      OFF_WORD2:  return 3'h2;
      OFF_WORD3:  return 3'h3;
      OFF_STATUS: return 3'h4;
      default:    return 3'h7;
    endcase
  endfunction

  // Reset image is a constant so the reset branch loads no logic
  localparam logic [CFG_W-1:0] CFG_RESET = build_cfg(WR_RESET, 7'h00);

  ccr_crc_if crc_link ();

  ccr_crc7 u_crc
  (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (crc_link.engine)
  );

  logic [5:0]           wr_bits_r;
  logic [5:0]           fused_r;
  logic [6:0]           crc_hold_r;
  logic [CONTENT_W-1:0] crc_src_r;
  logic                 seeded_r;
  logic                 crc_start;
  logic [CFG_W-1:0]     cfg_nxt;
  logic [CFG_W-1:0]     bare_img;
  logic [6:0]           crc_hold_nxt;
  logic [CONTENT_W-1:0] content_now;
  logic                 access;
  logic                 wr_word0;
  logic [2:0]           sel;

  // One wait state: answer lands on the second access cycle
  assign access   = psel && penable && !pready;
  assign sel      = word_sel(paddr);
  assign wr_word0 = access && pwrite && (sel == 3'h0);

  // fuse on first change away from reset, temporary lock rewritable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_bits_r <= WR_RESET;
      fused_r   <= 6'h00;
    end
    else if (wr_word0)
    begin
      for (int i = 0; i < 6; i++)
      begin
        if (!OTP_MASK[i])
          wr_bits_r[i] <= pwdata[WR_LO+i];
        else if (!fused_r[i] && pwdata[WR_LO+i] != WR_RESET[i])
        begin
          wr_bits_r[i] <= pwdata[WR_LO+i];
          fused_r[i]   <= 1'b1;
        end
      end
    end
  end

  // Checksum covers bits 127:8 only
  assign bare_img    = build_cfg(wr_bits_r, 7'h00);
  assign content_now = bare_img[CFG_W-1:CONTENT_LO];
  assign crc_start   = !crc_link.busy
                       && (!seeded_r || content_now != crc_src_r);
  assign crc_link.start = crc_start;
  assign crc_link.data  = content_now;

  // Start a fresh checksum when the content moves and no run is busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_src_r <= '0;
      seeded_r  <= 1'b0;
    end
    else if (crc_start)
    begin
      crc_src_r <= content_now;
      seeded_r  <= 1'b1;
    end
  end

  // Old checksum stays visible until a fresh one is ready
  assign crc_hold_nxt = (crc_link.done && !crc_start) ? crc_link.crc
                                                      : crc_hold_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crc_hold_r <= 7'h00;
    else
      crc_hold_r <= crc_hold_nxt;
  end

  // fresh checksum enters the image on the edge that raises valid
  assign cfg_nxt = build_cfg(wr_bits_r, crc_hold_nxt);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_specific_config <= CFG_RESET;
      config_valid         <= 1'b0;
    end
    else
    begin
      card_specific_config <= cfg_nxt;
      config_valid         <= crc_link.done && !crc_start && seeded_r;
    end
  end

  // read-only words accept the write and ignore it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && (sel == 3'h7);
      if (access && !pwrite)
      begin
        case (sel)
          3'h0:    prdata <= card_specific_config[31:0];
          3'h1:    prdata <= card_specific_config[63:32];
          3'h2:    prdata <= card_specific_config[95:64];
          3'h3:    prdata <= card_specific_config[127:96];
          3'h4:
          begin
            prdata <= '0;
            prdata[WR_HI:WR_LO]  <= fused_r;
            prdata[STAT_CRC_OK] <= config_valid;
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_VERSION: assert property (
    card_specific_config[127:126] == LAYOUT_VERSION)
    else $error("layout version wrong");
  AST_ASYNC: assert property (
    card_specific_config[119:112] ==
    (MULTI_LEVEL_CELL ? ASYNC_TIME_MLC : ASYNC_TIME_BINARY))
    else $error("async access time wrong");
  AST_FIXED: assert property (
    card_specific_config[111:84] ==
    {CLOCKED_TIME, TRANSFER_RATE, COMMAND_CLASS_MASK})
    else $error("clocked time, rate or class mask wrong");
  AST_BLOCK: assert property (
    card_specific_config[83:80] == BLOCK_LENGTH
    && card_specific_config[25:22] == BLOCK_LENGTH
    && card_specific_config[79] && !card_specific_config[21])
    else $error("block length or partial bits wrong");
  AST_CURRENT: assert property (
    card_specific_config[61:50] ==
    {READ_CUR_LOW, READ_CUR_HIGH, WRITE_CUR_LOW, WRITE_CUR_HIGH})
    else $error("current codes wrong");
  AST_ERASE: assert property (
    card_specific_config[46:29] ==
    {1'b1, ERASE_SECTOR_SIZE, PROTECT_GROUP_SIZE, 1'b1, 2'h0})
    else $error("erase or protect group fields wrong");
  AST_RATIO: assert property (
    card_specific_config[28:26] ==
    (MULTI_LEVEL_CELL ? WRITE_RATIO_MLC : WRITE_RATIO_BINARY))
    else $error("write speed ratio wrong");
  AST_STOP: assert property (
    card_specific_config[0] && (!config_valid ||
    card_specific_config[7:1] == crc_hold_r))
    else $error("stop bit or checksum wrong");
  AST_FUSE: assert property (
    fused_r[1] |=> $stable(wr_bits_r[1]) && fused_r[1])
    else $error("programmed format bit changed");
  AST_RO_WRITE: assert property (
    (access && pwrite && sel != 3'h0) |=>
    $stable(wr_bits_r) && $stable(fused_r))
    else $error("read-only word changed by write");
  AST_CRC_TIME: assert property (
    crc_start |=> !config_valid [*8] ##1 (crc_link.busy [*8]))
    else $error("checksum finished too early");
  AST_ANSWER: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one cycle");

  AST_WR_IMAGE: assert property (
    card_specific_config[WR_HI:WR_LO] == $past(wr_bits_r))
    else $error("programmable bits not shown in the image");
  AST_TMP_LOCK: assert property (
    wr_word0 |=> wr_bits_r[TMP_LOCK-WR_LO] == $past(pwdata[TMP_LOCK]))
    else $error("temporary lock not rewritten");
  AST_UNMAPPED: assert property (
    (access && sel == 3'h7) |=> pready && pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (
    (access && sel != 3'h7) |=> pready && !pslverr)
    else $error("mapped access refused");
  AST_STATUS_READ: assert property (
    (access && !pwrite && sel == 3'h4) |=>
    prdata[WR_HI:WR_LO] == $past(fused_r)
    && prdata[STAT_CRC_OK] == $past(config_valid))
    else $error("status word wrong");
  AST_WORD_READ: assert property (
    (access && !pwrite && sel == 3'h3) |=>
    prdata == $past(card_specific_config[127:96]))
    else $error("top word read wrong");
  AST_CAPACITY: assert property (
    card_specific_config[73:62] == CAPACITY_SIZE
    && card_specific_config[49:47] == CAPACITY_MULT)
    else $error("capacity fields wrong");
  AST_RESERVED: assert property (
    card_specific_config[125:120] == 6'h00
    && card_specific_config[78:74] == 5'h00
    && card_specific_config[30:29] == 2'h0
    && card_specific_config[20:16] == 5'h00
    && card_specific_config[9:8] == 2'h0)
    else $error("reserved bits not zero");
  AST_PROTECT: assert property (
    card_specific_config[38:31] == {PROTECT_GROUP_SIZE, 1'b1})
    else $error("protect group fields wrong");
  AST_PARTIAL: assert property (
    card_specific_config[79] && !card_specific_config[21])
    else $error("partial block bits wrong");
  AST_MATCH: assert property (
    config_valid |-> crc_src_r == card_specific_config[CFG_W-1:CONTENT_LO])
    else $error("valid raised over stale content");
  AST_DONE_VALID: assert property (
    (crc_link.done && !crc_start) |=> config_valid)
    else $error("finished checksum not reported");
endmodule

// file: core/ccr_pkg.sv
// Constants shared by the card configuration register block
package ccr_pkg;
  localparam int unsigned CFG_W      = 128;
  localparam int unsigned CONTENT_LO = 8;
  localparam int unsigned CONTENT_W  = 120;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam logic [6:0]  CRC_POLY   = 7'h09;
  localparam logic [6:0]  CRC_LAST   = 7'h77;

  localparam logic [7:0] OFF_WORD0  = 8'h00;
  localparam logic [7:0] OFF_WORD1  = 8'h04;
  localparam logic [7:0] OFF_WORD2  = 8'h08;
  localparam logic [7:0] OFF_WORD3  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int unsigned STAT_CRC_OK = 0;

  localparam logic [1:0]  LAYOUT_VERSION      = 2'h0;
  localparam logic [7:0]  ASYNC_TIME_BINARY   = 8'h26;
  localparam logic [7:0]  ASYNC_TIME_MLC      = 8'h0f;
  localparam logic [7:0]  CLOCKED_TIME        = 8'h00;
  localparam logic [7:0]  TRANSFER_RATE       = 8'h32;
  localparam logic [11:0] COMMAND_CLASS_MASK  = 12'h1f5;
  localparam logic [3:0]  BLOCK_LENGTH        = 4'h9;
  localparam logic [2:0]  READ_CUR_LOW        = 3'h4;
  localparam logic [2:0]  READ_CUR_HIGH       = 3'h3;
  localparam logic [2:0]  WRITE_CUR_LOW       = 3'h4;
  localparam logic [2:0]  WRITE_CUR_HIGH      = 3'h4;
  localparam logic [6:0]  ERASE_SECTOR_SIZE   = 7'h1f;
  localparam logic [6:0]  PROTECT_GROUP_SIZE  = 7'h7f;
  localparam logic [2:0]  WRITE_RATIO_BINARY  = 3'h4;
  localparam logic [2:0]  WRITE_RATIO_MLC     = 3'h2;

  // Writable bits 15:10; bit 12 is the rewritable temporary lock
  localparam int unsigned WR_LO       = 10;
  localparam int unsigned WR_HI       = 15;
  localparam int unsigned TMP_LOCK    = 12;
  localparam logic [5:0]  OTP_MASK    = 6'h3b;
  localparam logic [5:0]  WR_RESET    = 6'h10;

  typedef enum logic [1:0]
  {
    CRC_IDLE = 2'b00,
    CRC_RUN  = 2'b01,
    CRC_DONE = 2'b11
  } ccr_crc_state_t;
endpackage

// file: core/ccr_crc_if.sv
// Link between the register block and its checksum engine
interface ccr_crc_if;
  import ccr_pkg::*;
  logic                 start;
  logic [CONTENT_W-1:0] data;
  logic                 busy;
  logic                 done;
  logic [6:0]           crc;

  modport owner
  (
    output start,
    output data,
    input  busy,
    input  done,
    input  crc
  );
  modport engine
  (
    input  start,
    input  data,
    output busy,
    output done,
    output crc
  );
endinterface

// file: core/ccr_crc7.sv
// Serial seven-bit checksum over the register content, one bit per clock
module ccr_crc7
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  ccr_crc_if.engine   link
);
  import ccr_pkg::*;

  ccr_crc_state_t       state_r;
  logic [CONTENT_W-1:0] shift_r;
  logic [6:0]           count_r;
  logic [6:0]           crc_r;
  logic                 fb;

  assign fb = crc_r[6] ^ shift_r[CONTENT_W-1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= CRC_IDLE;
      count_r <= 7'h00;
    end
    else if (link.start)
    begin
      state_r <= CRC_RUN;
      count_r <= 7'h00;
    end
    else if (state_r == CRC_RUN)
    begin
      count_r <= count_r + 7'h01;
      if (count_r == CRC_LAST)
        state_r <= CRC_DONE;
    end
  end

  // Most significant bit enters first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_r <= '0;
      crc_r   <= 7'h00;
    end
    else if (link.start)
    begin
      shift_r <= link.data;
      crc_r   <= 7'h00;
    end
    else if (state_r == CRC_RUN)
    begin
      shift_r <= {shift_r[CONTENT_W-2:0], 1'b0};
      crc_r   <= {crc_r[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
    end
  end

  assign link.busy = (state_r == CRC_RUN);
  assign link.done = (state_r == CRC_DONE);
  assign link.crc  = crc_r;
endmodule

// file: tb/ccr_host_model.sv
// Host side model that issues APB transfers to the configuration register
module ccr_host_model
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // Setup, then access held until pready; only the watchdog ends a stall
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus does not keep showing the last request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// file: tb/card_config_data_register_tb.sv
// Self-checking bench for the card configuration register bank
module card_config_data_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;
  localparam logic [11:0] CSZ  = 12'h5a3;
  localparam logic [2:0]  CMUL = 3'h5;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [127:0] cfg;
  logic         cfg_ok;
  logic [127:0] cfg_mlc;
  logic         cfg_ok_mlc;
  logic [31:0]  rd;
  logic         er;
  int           err_count;
  int           checks;
  logic [7:0]   r_addr [6];
  logic [31:0]  r_exp  [6];
  logic [31:0]  r_mask [6];
  logic         r_err  [6];

  ccr_host_model ccr_host_model_i
  (
    .pclk    (pclk),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  ccr_config_reg #(.MULTI_LEVEL_CELL(1'b0), .CAPACITY_SIZE(CSZ),
                   .CAPACITY_MULT(CMUL)) ccr_config_reg_i
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .card_specific_config (cfg),
    .config_valid         (cfg_ok)
  );

  // Multi-level-cell model sees the same bus; only its image and valid flag are checked
  ccr_config_reg #(.MULTI_LEVEL_CELL(1'b1), .CAPACITY_SIZE(CSZ),
                   .CAPACITY_MULT(CMUL)) ccr_config_reg_mlc_i
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (),
    .pready               (),
    .pslverr              (),
    .card_specific_config (cfg_mlc),
    .config_valid         (cfg_ok_mlc)
  );

  always #2 pclk = ~pclk;

  // Checksum x^7+x^3+1, MSB first, zero start
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [127:0] img(input logic [5:0] wr);
    logic [119:0] b;
    b = {LAYOUT_VERSION, 6'h00, ASYNC_TIME_BINARY, CLOCKED_TIME,
         TRANSFER_RATE, COMMAND_CLASS_MASK, BLOCK_LENGTH, 1'b1, 5'h00,
         CSZ, READ_CUR_LOW, READ_CUR_HIGH, WRITE_CUR_LOW, WRITE_CUR_HIGH,
         CMUL, 1'b1, ERASE_SECTOR_SIZE, PROTECT_GROUP_SIZE, 1'b1, 2'b00,
         WRITE_RATIO_BINARY, BLOCK_LENGTH, 1'b0, 5'h00, wr, 2'b00};
    return {b, crc7(b), 1'b1};
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Recompute drops valid shortly after a write, then raises it again
  task automatic settle;
    int n;
    n = 0;
    while (cfg_ok === 1'b1 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (cfg_ok !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk(cfg_ok, 1'b1);
  endtask

  task automatic wr0(input logic [31:0] d, input logic [5:0] exp);
    ccr_host_model_i.xfer(1'b1, OFF_WORD0, d, rd, er);
    chk(er, 1'b0);
    settle();
    chk(cfg, img(exp));
    ccr_host_model_i.xfer(1'b0, OFF_WORD0, 32'h0, rd, er);
    chk(rd, img(exp)[31:0]);
  endtask

  initial
  begin
    #80000;
    err_count++;
    close_out();
  end

  initial
  begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    err_count = 0;
    checks    = 0;
    r_addr = '{OFF_WORD0, OFF_WORD1, OFF_WORD2, OFF_WORD3, OFF_STATUS,
               8'h14};
    r_exp  = '{img(6'h10)[31:0], img(6'h10)[63:32], img(6'h10)[95:64],
               img(6'h10)[127:96], 32'h0000_0001, 32'h0000_0000};
    r_mask = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
               32'h0000_fc01, 32'hffff_ffff};
    r_err  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    repeat (16) @(posedge pclk);
    // Reset image holds constants with the checksum field cleared
    chk(cfg, img(6'h10) & ~128'hfe);
    chk({cfg_ok, pready}, 2'b00);
    presetn <= 1'b1;
    settle();
    chk(cfg, img(6'h10));
    for (int i = 0; i < 6; i++)
    begin
      ccr_host_model_i.xfer(1'b0, r_addr[i], 32'h0, rd, er);
      chk(rd & r_mask[i], r_exp[i] & r_mask[i]);
      chk(er, r_err[i]);
    end
    // Read-only words ignore writes
    ccr_host_model_i.xfer(1'b1, OFF_WORD3, 32'hffff_ffff, rd, er);
    chk(er, 1'b0);
    ccr_host_model_i.xfer(1'b1, OFF_WORD1, 32'h0000_0000, rd, er);
    ccr_host_model_i.xfer(1'b1, 8'h14, 32'hffff_ffff, rd, er);
    chk(er, 1'b1);
    ccr_host_model_i.xfer(1'b0, OFF_WORD3, 32'h0, rd, er);
    chk(rd, img(6'h10)[127:96]);
    chk(cfg, img(6'h10));
    // Fuse sequence: set all, clear all, set all again
    wr0(32'hffff_ffff, 6'h3f);
    wr0(32'h0000_0000, 6'h2b);
    wr0(32'hffff_ffff, 6'h2f);
    ccr_host_model_i.xfer(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk(rd & 32'h0000_fc01, 32'h0000_ec01);
    // Mid-run reset returns every output to its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(cfg, img(6'h10) & ~128'hfe);
    chk({cfg_ok, pready, pslverr, prdata}, 35'h0);
    presetn <= 1'b1;
    settle();
    chk(cfg, img(6'h10));
    ccr_host_model_i.xfer(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0000_0001);
    chk(cfg_ok_mlc, 1'b1);
    chk(cfg_mlc[119:112], ASYNC_TIME_MLC);
    chk(cfg_mlc[28:26], WRITE_RATIO_MLC);
    close_out();
  end
endmodule
